//--- hw/frt_capture_chan.sv
`timescale 1ns/10ps
`default_nettype none

module frt_capture_chan (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        cap_pin,
  input  wire logic [1:0]  edge_sel,
  input  wire logic [15:0] count_val,
  output logic      [15:0] cap_value_q,
  output logic             cap_event_q
);

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic       rise;
  logic       fall;
  logic       hit;

  // The pin is asynchronous to clk_sys; only sync2_q reads sync1_q.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= cap_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  always_comb begin
    unique case (edge_sel)
      frt_pkg::FRT_EDGE_RISE: hit = rise;
      frt_pkg::FRT_EDGE_FALL: hit = fall;
      frt_pkg::FRT_EDGE_BOTH: hit = rise | fall;
      frt_pkg::FRT_EDGE_OFF:  hit = 1'b0;
    endcase
  end

  // The value is meaningless until the first capture.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_value_q <= frt_pkg::FRT_CAP_RST;
    end else if (hit) begin
      cap_value_q <= count_val;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_event_q <= 1'b0;
    end else begin
      cap_event_q <= hit;
    end
  end

endmodule : frt_capture_chan

`default_nettype wire

//--- hw/frt_pkg.sv
package frt_pkg;

  localparam int unsigned FRT_CLK_HZ     = 100_000_000;
  localparam int unsigned FRT_CNT_W      = 16;
  localparam int unsigned FRT_NCAP       = 4;
  localparam int unsigned FRT_NEV        = 5;
  localparam int unsigned FRT_AW         = 6;

  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [5:0] FRT_OFS_TCTRL   = 6'h00;
  localparam logic [5:0] FRT_OFS_COUNT   = 6'h04;
  localparam logic [5:0] FRT_OFS_CCTRL_A = 6'h08;
  localparam logic [5:0] FRT_OFS_CCTRL_B = 6'h0C;
  localparam logic [5:0] FRT_OFS_CAP0    = 6'h10;
  localparam logic [5:0] FRT_OFS_CAP1    = 6'h14;
  localparam logic [5:0] FRT_OFS_CAP2    = 6'h18;
  localparam logic [5:0] FRT_OFS_CAP3    = 6'h1C;
  localparam logic [5:0] FRT_OFS_STATUS  = 6'h20;
  localparam logic [5:0] FRT_OFS_MASK    = 6'h24;

  // Timer control/status fields.
  localparam int unsigned FRT_TC_DIV_LSB = 0;
  localparam int unsigned FRT_TC_CLR_BIT = 2;
  localparam int unsigned FRT_TC_IE_BIT  = 3;
  localparam int unsigned FRT_TC_IOS_BIT = 4;
  localparam int unsigned FRT_TC_W       = 5;

  // Capture control/status fields, per channel within a unit.
  localparam int unsigned FRT_CC_EDGE_LSB = 0;
  localparam int unsigned FRT_CC_IE_LSB   = 4;
  localparam int unsigned FRT_CC_IOS_LSB  = 6;
  localparam int unsigned FRT_CC_W        = 8;

  // Event bit positions in status and mask.
  localparam int unsigned FRT_EV_OVF     = 0;
  localparam int unsigned FRT_EV_CAP0    = 1;

  // Edge selection codes.
  localparam logic [1:0] FRT_EDGE_OFF    = 2'h0;
  localparam logic [1:0] FRT_EDGE_RISE   = 2'h1;
  localparam logic [1:0] FRT_EDGE_FALL   = 2'h2;
  localparam logic [1:0] FRT_EDGE_BOTH   = 2'h3;

  // Prescaler masks: tick when masked prescaler bits are all ones.
  localparam logic [3:0] FRT_DIV_MASK0   = 4'h1;
  localparam logic [3:0] FRT_DIV_MASK1   = 4'h3;
  localparam logic [3:0] FRT_DIV_MASK2   = 4'h7;
  localparam logic [3:0] FRT_DIV_MASK3   = 4'hF;

  localparam logic [15:0] FRT_CNT_RST    = 16'h0000;
  localparam logic [15:0] FRT_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] FRT_CAP_RST    = 16'h0000;
  localparam logic [4:0]  FRT_TC_RST     = 5'h00;
  localparam logic [7:0]  FRT_CC_RST     = 8'h00;
  localparam logic [4:0]  FRT_EV_RST     = 5'h00;
  localparam logic [3:0]  FRT_PRE_RST    = 4'h0;

endpackage : frt_pkg

//--- hw/frt_top.sv
// What this block does
// - One 16-bit free-running up counter advancing on each prescaled tick.
// - Control field picks one of four machine-clock division ratios.
// - Counter overflow raises an interrupt when overflow enable and its mask bit are both set.
// - Overflow can instead start the intelligent I/O service.
// - Counter clears to 0000 on reset and on a clear-bit write.
// - Counter value feeds every capture channel as the time base.
// - Selected pin edge copies the counter into the channel's register.
// - Each channel detects rising, falling or both edges.
// - A detected edge raises an interrupt if the channel enable and its mask bit are both set.
// - A capture can instead start the intelligent I/O service.
// - Two capture units of two pins, one control register each.
// - Four pins, each with its own capture data register.
// - Capture registers are 16-bit, read-only, reading 0000 from reset until first capture.
// - The capture latch event itself issues the channel's request.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

module frt_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  cap_pin,
  output logic             irq,
  output logic      [4:0]  ios_start
);

  logic [4:0]  tctrl_q;
  logic [7:0]  cctrl_a_q;
  logic [7:0]  cctrl_b_q;
  logic [15:0] count_q;
  logic [3:0]  pre_q;
  logic        tick_q;
  logic        ovf_ev_q;
  logic [4:0]  status_q;
  logic [4:0]  mask_q;
  logic [31:0] rdata_q;
  logic        wait_q;
  logic        irq_q;
  logic [4:0]  ios_q;

  logic        req;
  logic        load_cnt;
  logic        wr_done;
  logic        rd_done;
  logic [31:0] rd_mux;
  logic [3:0]  div_mask;
  logic        tick_d;
  logic        clr_req;
  logic [15:0] cap_val [4];
  logic [3:0]  cap_ev;
  logic [4:0]  ev;
  logic [4:0]  ev_ie;
  logic [4:0]  ev_ios;
  logic [4:0]  to_ios;
  logic [4:0]  to_flag;
  logic [4:0]  rd_clr;
  logic [4:0]  status_d;

  // Merge written byte lanes into an old value.
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Pick one channel's field out of a unit's control register.
  function automatic logic [1:0] chan_edge(
    input logic [7:0] cc,
    input logic       ch
  );
    return cc[frt_pkg::FRT_CC_EDGE_LSB + 2*ch +: 2];
  endfunction : chan_edge

  // Pick one channel's bit from a pair, such as its enable or service bit.
  function automatic logic chan_bit(
    input logic [7:0] cc,
    input int unsigned lsb,
    input logic       ch
  );
    return cc[lsb + ch];
  endfunction : chan_bit

  // True when a write to the given register completes in this cycle.
  function automatic logic wr_hit(
    input logic       done,
    input logic [5:0] addr,
    input logic [5:0] ofs
  );
    return done && addr == ofs;
  endfunction : wr_hit

  // Bus handshake: waitrequest drops one cycle after a request appears.
  assign req      = avs_read | avs_write;
  assign wr_done  = avs_write & ~wait_q;
  assign rd_done  = avs_read & ~wait_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      frt_pkg::FRT_OFS_TCTRL: begin
        rd_mux[4:0] = tctrl_q;
      end
      frt_pkg::FRT_OFS_COUNT: begin
        rd_mux[15:0] = count_q;
      end
      frt_pkg::FRT_OFS_CCTRL_A: begin
        rd_mux[7:0] = cctrl_a_q;
      end
      frt_pkg::FRT_OFS_CCTRL_B: begin
        rd_mux[7:0] = cctrl_b_q;
      end
      frt_pkg::FRT_OFS_CAP0: begin
        rd_mux[15:0] = cap_val[0];
      end
      frt_pkg::FRT_OFS_CAP1: begin
        rd_mux[15:0] = cap_val[1];
      end
      frt_pkg::FRT_OFS_CAP2: begin
        rd_mux[15:0] = cap_val[2];
      end
      frt_pkg::FRT_OFS_CAP3: begin
        rd_mux[15:0] = cap_val[3];
      end
      frt_pkg::FRT_OFS_STATUS: begin
        rd_mux[4:0] = status_q;
      end
      frt_pkg::FRT_OFS_MASK: begin
        rd_mux[4:0] = mask_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data is sampled in the waiting cycle and held for the answer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // Control registers. The clear bit is a strobe and always reads zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tctrl_q <= frt_pkg::FRT_TC_RST;
    end else if (wr_hit(wr_done, avs_address, frt_pkg::FRT_OFS_TCTRL)) begin
      tctrl_q <= 5'(be_merge({27'h0, tctrl_q}, avs_writedata,
                             avs_byteenable));
      tctrl_q[frt_pkg::FRT_TC_CLR_BIT] <= 1'b0;
    end
  end

  // Edge, enable and service bits of both channels share one register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cctrl_a_q <= frt_pkg::FRT_CC_RST;
    end else if (wr_hit(wr_done, avs_address, frt_pkg::FRT_OFS_CCTRL_A)) begin
      cctrl_a_q <= 8'(be_merge({24'h0, cctrl_a_q}, avs_writedata,
                               avs_byteenable));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cctrl_b_q <= frt_pkg::FRT_CC_RST;
    end else if (wr_hit(wr_done, avs_address, frt_pkg::FRT_OFS_CCTRL_B)) begin
      cctrl_b_q <= 8'(be_merge({24'h0, cctrl_b_q}, avs_writedata,
                               avs_byteenable));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= frt_pkg::FRT_EV_RST;
    end else if (wr_hit(wr_done, avs_address, frt_pkg::FRT_OFS_MASK)) begin
      mask_q <= 5'(be_merge({27'h0, mask_q}, avs_writedata,
                            avs_byteenable));
    end
  end

  // The clear strobe acts in the completing cycle and is never stored.
  assign clr_req = wr_hit(wr_done, avs_address, frt_pkg::FRT_OFS_TCTRL) &&
                   avs_byteenable[0] &&
                   avs_writedata[frt_pkg::FRT_TC_CLR_BIT];

  // A software load of the counter also hides an overflow in that cycle.
  assign load_cnt = wr_hit(wr_done, avs_address, frt_pkg::FRT_OFS_COUNT);

  // Prescaler. A clear restarts it so the first tick after a clear is
  // a full period away.
  always_comb begin
    unique case (tctrl_q[frt_pkg::FRT_TC_DIV_LSB +: 2])
      2'h0: div_mask = frt_pkg::FRT_DIV_MASK0;
      2'h1: div_mask = frt_pkg::FRT_DIV_MASK1;
      2'h2: div_mask = frt_pkg::FRT_DIV_MASK2;
      2'h3: div_mask = frt_pkg::FRT_DIV_MASK3;
    endcase
  end

  assign tick_d = ((pre_q & div_mask) == div_mask) & ~clr_req;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= frt_pkg::FRT_PRE_RST;
    end else if (clr_req) begin
      pre_q <= frt_pkg::FRT_PRE_RST;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Registering the tick gives the counter a clean one-cycle enable.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  // Counter: clear beats a software load, which beats a tick.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= frt_pkg::FRT_CNT_RST;
    end else if (clr_req) begin
      count_q <= frt_pkg::FRT_CNT_RST;
    end else if (load_cnt) begin
      count_q <= 16'(be_merge({16'h0, count_q}, avs_writedata,
                              avs_byteenable));
    end else if (tick_q) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Overflow is the tick that wraps the counter to zero. A clear or load
  // in the same cycle wins, so no false overflow follows a reload.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovf_ev_q <= 1'b0;
    end else begin
      ovf_ev_q <= tick_q & ~clr_req & (count_q == frt_pkg::FRT_CNT_MAX) &
                  ~load_cnt;
    end
  end

  // Four channels in two units; each unit's register serves two pins.
  for (genvar g = 0; g < frt_pkg::FRT_NCAP; g++) begin : g_cap
    logic [7:0] cc;
    assign cc = (g < 2) ? cctrl_a_q : cctrl_b_q;

    frt_capture_chan u_chan (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .cap_pin     (cap_pin[g]),
      .edge_sel    (chan_edge(cc, 1'(g % 2))),
      .count_val   (count_q),
      .cap_value_q (cap_val[g]),
      .cap_event_q (cap_ev[g])
    );

    assign ev_ie[frt_pkg::FRT_EV_CAP0 + g] =
      chan_bit(cc, frt_pkg::FRT_CC_IE_LSB, 1'(g % 2));
    assign ev_ios[frt_pkg::FRT_EV_CAP0 + g] =
      chan_bit(cc, frt_pkg::FRT_CC_IOS_LSB, 1'(g % 2));
  end

  assign ev_ie[frt_pkg::FRT_EV_OVF]  = tctrl_q[frt_pkg::FRT_TC_IE_BIT];
  assign ev_ios[frt_pkg::FRT_EV_OVF] = tctrl_q[frt_pkg::FRT_TC_IOS_BIT];
  assign ev = {cap_ev, ovf_ev_q};

  // An enabled event routed to the service does not touch the flags.
  assign to_ios  = ev & ev_ie & ev_ios;
  assign to_flag = ev & ~to_ios;

  // Reading status clears only the bits that were returned, so an event
  // landing between sampling and completion stays pending.
  assign rd_clr = (rd_done && avs_address == frt_pkg::FRT_OFS_STATUS) ?
                  rdata_q[4:0] : frt_pkg::FRT_EV_RST;
  assign status_d = (status_q & ~rd_clr) | to_flag;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= frt_pkg::FRT_EV_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // The per-source enable gates the level as well as the mask, so a
  // disabled source can still be polled in the status register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q & ev_ie);
    end
  end

  // Service starts are one-cycle strobes; the service side must take
  // each one in the cycle it stands, as nothing here holds it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ios_q <= frt_pkg::FRT_EV_RST;
    end else begin
      ios_q <= to_ios;
    end
  end

  assign irq       = irq_q;
  assign ios_start = ios_q;

endmodule : frt_top

`default_nettype wire

//--- verification/frt_checker.sv
`timescale 1ns/10ps
`default_nettype none
module frt_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  cap_pin,
  input wire logic        irq,
  input wire logic [4:0]  ios_start
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic       rd_done;
  logic       clr_seen_q;
  logic       pin0_q;
  logic [3:0] pin_age_q;
  assign rd_done = avs_read && !avs_waitrequest;
  // Only the first read after a clear is judged, so tick drift stays small.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_seen_q <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == 6'h00) begin
      clr_seen_q <= avs_writedata[2] && avs_byteenable[0];
    end else if (rd_done) begin
      clr_seen_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin0_q    <= 1'b0;
      pin_age_q <= 4'hF;
    end else begin
      pin0_q <= cap_pin[0];
      if (cap_pin[0] != pin0_q) begin
        pin_age_q <= 4'h0;
      end else if (pin_age_q != 4'hF) begin
        pin_age_q <= pin_age_q + 4'h1;
      end
    end
  end
  property p_wait_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ack: assert property (p_wait_ack)
    else $error("no answer one cycle after request");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  property p_wait_idle;
    !(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest low while idle");
  property p_ios_pulse;
    ios_start != 5'h00 |=> (ios_start & $past(ios_start)) == 5'h00;
  endproperty
  a_ios_pulse: assert property (p_ios_pulse)
    else $error("service start longer than one cycle");
  property p_cnt_w;
    rd_done && avs_address == 6'h04 |-> avs_readdata[31:16] == 16'h0000;
  endproperty
  a_cnt_w: assert property (p_cnt_w)
    else $error("counter wider than 16 bits");
  property p_clr_rd;
    rd_done && avs_address == 6'h00 |-> avs_readdata[2] == 1'b0;
  endproperty
  a_clr_rd: assert property (p_clr_rd)
    else $error("clear bit reads back as one");
  property p_clr_cnt;
    rd_done && clr_seen_q && avs_address == 6'h04
      |-> avs_readdata[15:0] < 16'h0010;
  endproperty
  a_clr_cnt: assert property (p_clr_cnt)
    else $error("counter not cleared");
  property p_cap_src;
    ios_start[1] |-> pin_age_q <= 4'h8;
  endproperty
  a_cap_src: assert property (p_cap_src)
    else $error("capture request without pin edge");
endmodule : frt_checker
bind frt_top frt_checker i_frt_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cap_pin(cap_pin), .irq(irq), .ios_start(ios_start)
);
`default_nettype wire

//--- verification/frt_pin_drv.sv
`timescale 1ns/10ps
`default_nettype none
module frt_pin_drv (
  input  wire logic       clk_sys,
  output logic      [3:0] pins
);
  initial pins = 4'h0;
  // Pins move just after a rising edge; the design's synchroniser takes
  // them from the next edge on.
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk_sys);
    pins[ch] <= v;
  endtask : set_pin
endmodule : frt_pin_drv
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [5:0] ad; logic [31:0] d; logic [31:0] rv; logic [31:0] e;
  } frt_row_s;
  logic        clk_sys;
  logic        rst_n;
  logic [5:0]  a;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wt;
  logic [3:0]  pins;
  logic        irq;
  logic [4:0]  ios;
  logic [31:0] q;
  logic [31:0] t0;
  int          err_count;
  int          checked;
  int          cyc;
  int          i;
  frt_row_s    rows [5] = '{
    '{6'h00, 32'h1F, 32'h0, 32'h1B}, '{6'h08, 32'hFF, 32'h0, 32'hFF},
    '{6'h0C, 32'hA5, 32'h0, 32'hA5}, '{6'h24, 32'h1F, 32'h0, 32'h1F},
    '{6'h28, 32'hFF, 32'h0, 32'h0}};
  frt_top i_frt_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(a), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wt), .cap_pin(pins),
    .irq(irq), .ios_start(ios));
  frt_pin_drv i_frt_pin_drv (.clk_sys(clk_sys), .pins(pins));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Request held until waitrequest is sampled low; data taken there.
  task automatic bus(input logic w, input logic [5:0] ad,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    a  <= ad;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk_sys); while (wt !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    rst_n = 1'b0;
    a = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    be = 4'hF;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      bus(0, rows[k].ad, 0, q);
      chk(q, rows[k].rv);
      bus(1, rows[k].ad, rows[k].d, q);
      bus(0, rows[k].ad, 0, q);
      chk(q, rows[k].e);
    end
    be <= 4'h2;
    bus(1, 6'h00, 32'h0, q);
    be <= 4'hF;
    bus(0, 6'h00, 0, q);
    chk(q, 32'h1B);
    bus(1, 6'h08, 0, q);
    bus(1, 6'h0C, 0, q);
    for (int d = 0; d < 4; d++) begin
      bus(1, 6'h00, 32'(d) | 32'h4, q);
      bus(0, 6'h04, 0, q);
      chk(32'(q < 32'h10), 1);
      repeat (256) @(posedge clk_sys);
      bus(0, 6'h04, 0, q);
      chk(32'(q >= 256 / (2 << d) && q <= 270 / (2 << d) + 1), 1);
    end
    bus(1, 6'h00, 32'h8, q);
    bus(0, 6'h20, 0, q);
    bus(1, 6'h04, 32'hFFF0, q);
    for (i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk_sys);
    chk(irq, 1);
    bus(0, 6'h20, 0, q);
    chk(q & 32'h1, 1);
    repeat (2) @(posedge clk_sys);
    chk(irq, 0);
    bus(1, 6'h24, 32'h1E, q);
    bus(1, 6'h04, 32'hFFF0, q);
    repeat (60) @(posedge clk_sys);
    chk(irq, 0);
    bus(0, 6'h20, 0, q);
    chk(q & 32'h1, 1);
    bus(1, 6'h24, 32'h1F, q);
    bus(1, 6'h00, 32'h18, q);
    bus(1, 6'h04, 32'hFFF0, q);
    for (i = 0; i < 100 && ios[0] !== 1'b1; i++) @(posedge clk_sys);
    chk(ios[0], 1);
    bus(0, 6'h20, 0, q);
    chk(q & 32'h1, 0);
    bus(1, 6'h00, 32'h0, q);
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 4; m++) begin
        bus(1, 6'h08 + 6'(4 * (c / 2)),
            32'(m << (2 * (c % 2))) | 32'(1 << (4 + c % 2)), q);
        bus(0, 6'h20, 0, q);
        bus(0, 6'h04, 0, q);
        t0 = q;
        i_frt_pin_drv.set_pin(c, 1'b1);
        repeat (8) @(posedge clk_sys);
        chk(irq, m[0]);
        bus(0, 6'h20, 0, q);
        chk((q >> (c + 1)) & 1, m[0]);
        if (m == 1) begin
          bus(0, 6'h10 + 6'(4 * c), 0, q);
          chk(32'(q - t0 < 32'h20), 1);
        end
        i_frt_pin_drv.set_pin(c, 1'b0);
        repeat (8) @(posedge clk_sys);
        bus(0, 6'h20, 0, q);
        chk((q >> (c + 1)) & 1, m[1]);
      end
    end
    bus(1, 6'h0C, 0, q);
    bus(1, 6'h08, 32'h51, q);
    bus(0, 6'h20, 0, q);
    i_frt_pin_drv.set_pin(0, 1'b1);
    for (i = 0; i < 20 && ios[1] !== 1'b1; i++) @(posedge clk_sys);
    chk(ios[1], 1);
    bus(0, 6'h20, 0, q);
    chk(q & 32'h2, 0);
    bus(1, 6'h04, 32'h8000, q);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(wt, 1);
    rst_n <= 1'b1;
    bus(0, 6'h04, 0, q);
    chk(32'(q < 32'h10), 1);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
